// ==== hw/i2c_tx_consts.svh ====
// Purpose: constants of the I2C master transmit path
// Assumes: register index times four is the APB byte address
// Notes: the event and mask registers sit just above the status block
`ifndef I2C_TX_CONSTS_SVH
`define I2C_TX_CONSTS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define BUS_CONTROL_ONE_IDX 16'hf078
`define BUS_STATUS_IDX 16'hf07c
`define TRANSMIT_BUFFER_IDX 16'hf07e
`define EVENT_STATUS_IDX 16'hf080
`define EVENT_MASK_IDX 16'hf081

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MST_BIT 5
`define TRS_BIT 4
`define TX_BUFFER_EMPTY_FLAG_BIT 7
`define TX_END_FLAG_BIT 6
`define AL_BIT 2

// ----------------------------------------
// Reset values and link counts
// ----------------------------------------
`define BUS_CONTROL_ONE_RST 8'h00
`define BUS_STATUS_RST 8'h00
`define TRANSMIT_BUFFER_RST 8'hff
`define EVENT_RST 8'h00
`define DATA_BITS 4'h8

`endif

// ==== hw/i2c_tx_pkg.sv ====
// Purpose: shared types of the I2C master transmit path
// Assumes: nothing beyond the constants header
// Notes: mode enum order matches the two-bit select encoding
package i2c_tx_pkg;

   typedef enum logic [1:0] {
      SLAVE_RX,
      SLAVE_TX,
      MASTER_RX,
      MASTER_TX
   } op_mode_t;

   typedef enum logic [2:0] {
      REG_CTRL,
      REG_STAT,
      REG_TXB,
      REG_EV,
      REG_MASK,
      REG_NONE
   } reg_id_t;

   typedef enum logic {
      SH_IDLE,
      SH_SHIFT
   } shift_state_t;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic sda_lvl;
   } link_evt_t;

endpackage

// ==== hw/i2c_pin_sync.sv ====
// Purpose: two-stage synchroniser with edge pulses for one bus pin
// Assumes: pin is asynchronous to pclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module i2c_pin_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin
   input wire logic pin,
   // Synchronised view
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // Pins idle high on a pulled-up bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

// ==== hw/i2c_tx_shifter.sv ====
// Purpose: byte shifter driving SDA in master transmit
// Assumes: SCL edges come synchronised, start condition made elsewhere
// Notes: open-drain output, enable low pulls SDA low
`timescale 1ns/1ns
module i2c_tx_shifter
   import i2c_tx_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Load from the transmit buffer
   input wire logic load,
   input wire logic [7:0] load_data,
   // Link view
   input i2c_tx_pkg::link_evt_t link,
   // Results
   output logic busy,
   output logic sda_oe_n,
   output logic ninth_rise,
   output logic arb_lost
);
   `include "i2c_tx_consts.svh"

   shift_state_t state_r;
   logic [7:0] shift_register;
   logic [3:0] cnt_r;
   logic seen_rise_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= SH_IDLE;
         shift_register <= 8'h00;
         cnt_r <= 4'h0;
         seen_rise_r <= 1'b0;
         sda_oe_n <= 1'b1;
         ninth_rise <= 1'b0;
         arb_lost <= 1'b0;
      end else begin
         ninth_rise <= 1'b0;
         arb_lost <= 1'b0;
         case (state_r)
            SH_IDLE: begin
               if (load) begin
                  state_r <= SH_SHIFT;
                  shift_register <= load_data;
                  cnt_r <= 4'h0;
                  seen_rise_r <= 1'b0;
                  sda_oe_n <= load_data[7];
               end
            end
            SH_SHIFT: begin
               if (link.scl_rise) begin
                  seen_rise_r <= 1'b1;
                  if (cnt_r == `DATA_BITS) begin
                     ninth_rise <= 1'b1;
                  end else if (sda_oe_n && !link.sda_lvl) begin
                     // Released a one but bus reads low
                     arb_lost <= 1'b1;
                     state_r <= SH_IDLE;
                     sda_oe_n <= 1'b1;
                  end
               end else if (link.scl_fall && seen_rise_r) begin
                  seen_rise_r <= 1'b0;
                  if (cnt_r == `DATA_BITS) begin
                     state_r <= SH_IDLE;
                     sda_oe_n <= 1'b1;
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                     shift_register <= {shift_register[6:0], 1'b0};
                     // Release for the acknowledge clock
                     sda_oe_n <= (cnt_r == `DATA_BITS - 4'h1) ? 1'b1 :
                                 shift_register[6];
                  end
               end
            end
            default: begin
               state_r <= SH_IDLE;
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   assign busy = (state_r != SH_IDLE);
endmodule

// ==== hw/i2c_master_transmit_path.sv ====
// Purpose: I2C master transmit path with APB register access
// Assumes: SCL is sampled from the pin; start and stop made elsewhere
// Notes: I2C format assumed throughout; receive path lives elsewhere
//
// What this block does
// - The master-select and transmit-select bits decode as 00 slave rx, 01 slave tx, 10 master rx, 11 master tx.
// - The buffer-empty flag sets when the buffered byte moves into the shift register.
// - The buffer-empty flag also sets whenever transmit-select is written to one.
// - The buffer-empty flag clears on a zero written after reading it as one, or on a buffer write.
// - The transmit-end flag sets at the ninth SCL rising edge while buffer-empty is one.
// - The transmit-end flag clears on a zero written after reading it as one, or on a buffer write.
// - The transmit buffer is an 8-bit read/write register holding the next byte.
// - When the shift register has room the buffered byte is copied in and shifted out.
// - The next byte may be written while the previous one is being moved to the shifter.
// - The transmit buffer resets to all ones.
// - Losing arbitration as master clears master-select and transmit-select.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module i2c_master_transmit_path
   import i2c_tx_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Status
   output i2c_tx_pkg::op_mode_t mode,
   output logic irq
);
   `include "i2c_tx_consts.svh"

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic reg_id_t reg_decode(input logic [17:0] addr);
      reg_id_t id;
      id = REG_NONE;
      // Misaligned or unlisted addresses stay REG_NONE and are refused
      if (addr[1:0] == 2'h0) begin
         case (addr[17:2])
            `BUS_CONTROL_ONE_IDX: id = REG_CTRL;
            `BUS_STATUS_IDX: id = REG_STAT;
            `TRANSMIT_BUFFER_IDX: id = REG_TXB;
            `EVENT_STATUS_IDX: id = REG_EV;
            `EVENT_MASK_IDX: id = REG_MASK;
            default: id = REG_NONE;
         endcase
      end
      return id;
   endfunction

   function automatic op_mode_t mode_decode(input logic master_select, input logic trs);
      op_mode_t m;
      case ({master_select, trs})
         2'b00: m = SLAVE_RX;
         2'b01: m = SLAVE_TX;
         2'b10: m = MASTER_RX;
         default: m = MASTER_TX;
      endcase
      return m;
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] bus_control_one;
   logic [7:0] transmit_buffer;
   logic tx_buffer_empty_flag_r;
   logic tx_end_flag_r;
   logic al_r;
   logic [7:0] arm_r;
   logic [7:0] ev_r;
   logic [7:0] mask_r;
   logic [7:0] status_view;
   logic [7:0] rd_mux;
   reg_id_t sel_id;
   logic access;
   logic xfer;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_txb;
   logic wr_ev;
   logic wr_mask;
   logic load;
   logic busy;
   logic ninth_rise;
   logic arb_lost;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   link_evt_t link;
   logic set_tx_buffer_empty_flag;
   logic clr_tx_buffer_empty_flag_sw;
   logic clr_tx_end_flag_sw;
   logic clr_al_sw;
   logic [7:0] ev_set;

   // ----------------------------------------
   // Pin synchronisers and shifter
   // ----------------------------------------
   i2c_pin_sync u_scl_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(scl_in),
      .level(),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   i2c_pin_sync u_sda_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(sda_in),
      .level(sda_lvl),
      .rise(),
      .fall()
   );

   // ----------------------------------------
   // Link events
   // ----------------------------------------
   // Both pins share one sync depth, so data and clock edges line up
   always_comb begin
      link = '0;
      link.scl_rise = scl_rise;
      link.scl_fall = scl_fall;
      link.sda_lvl = sda_lvl;
   end

   i2c_tx_shifter u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .load_data(transmit_buffer),
      .link(link),
      .busy(busy),
      .sda_oe_n(sda_oe_n),
      .ninth_rise(ninth_rise),
      .arb_lost(arb_lost)
   );

   // Open drain: only low is ever driven
   // The enable alone decides the wire level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state so that every output comes from a flip-flop
   assign sel_id = reg_decode(paddr);
   assign access = psel & penable & ~pready;
   assign xfer = psel & penable & pready;
   assign wr_ctrl = xfer & pwrite & (sel_id == REG_CTRL);
   assign wr_stat = xfer & pwrite & (sel_id == REG_STAT);
   assign wr_txb = xfer & pwrite & (sel_id == REG_TXB);
   assign wr_ev = xfer & pwrite & (sel_id == REG_EV);
   assign wr_mask = xfer & pwrite & (sel_id == REG_MASK);

   // Unused status bits read as zero
   assign status_view = {tx_buffer_empty_flag_r, tx_end_flag_r, 3'b000, al_r, 2'b00};

   always_comb begin
      case (sel_id)
         REG_CTRL: rd_mux = bus_control_one;
         REG_STAT: rd_mux = status_view;
         REG_TXB: rd_mux = transmit_buffer;
         REG_EV: rd_mux = ev_r;
         REG_MASK: rd_mux = mask_r;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & (sel_id == REG_NONE);
         if (access && !pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   // Flags seen as one by a status read may later be cleared by zero
   // Any status write disarms all, so one status read arms at most one clearing write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_r <= 8'h00;
      end else if (access && !pwrite && sel_id == REG_STAT) begin
         arm_r <= status_view;
      end else if (wr_stat) begin
         arm_r <= 8'h00;
      end
   end

   assign clr_tx_buffer_empty_flag_sw = wr_stat & ~pwdata[`TX_BUFFER_EMPTY_FLAG_BIT] & arm_r[`TX_BUFFER_EMPTY_FLAG_BIT];
   assign clr_tx_end_flag_sw = wr_stat & ~pwdata[`TX_END_FLAG_BIT] & arm_r[`TX_END_FLAG_BIT];
   assign clr_al_sw = wr_stat & ~pwdata[`AL_BIT] & arm_r[`AL_BIT];

   // ----------------------------------------
   // Control and mode
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_control_one <= `BUS_CONTROL_ONE_RST;
      end else begin
         if (wr_ctrl) begin
            bus_control_one <= pwdata[7:0];
         end
         // Arbitration clear wins over a same-cycle control write
         if (arb_lost) begin
            bus_control_one[`MST_BIT] <= 1'b0;
            bus_control_one[`TRS_BIT] <= 1'b0;
         end
      end
   end

   // Registered so the mode output comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= SLAVE_RX;
      end else begin
         mode <= mode_decode(bus_control_one[`MST_BIT],
                             bus_control_one[`TRS_BIT]);
      end
   end

   // ----------------------------------------
   // Transmit buffer and load
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_buffer <= `TRANSMIT_BUFFER_RST;
      end else if (wr_txb) begin
         transmit_buffer <= pwdata[7:0];
      end
   end

   // Load when in master transmit, byte pending and shifter free
   // A same-cycle arbitration loss must not start a new byte
   assign load = (mode_decode(bus_control_one[`MST_BIT], bus_control_one[`TRS_BIT])
                  == MASTER_TX) & ~tx_buffer_empty_flag_r & ~busy & ~arb_lost;

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   assign set_tx_buffer_empty_flag = load | (wr_ctrl & pwdata[`TRS_BIT]);

   // A buffer write in the load cycle keeps the new byte pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buffer_empty_flag_r <= 1'(`BUS_STATUS_RST >> `TX_BUFFER_EMPTY_FLAG_BIT);
      end else if (wr_txb) begin
         tx_buffer_empty_flag_r <= 1'b0;
      end else if (set_tx_buffer_empty_flag) begin
         tx_buffer_empty_flag_r <= 1'b1;
      end else if (clr_tx_buffer_empty_flag_sw) begin
         tx_buffer_empty_flag_r <= 1'b0;
      end
   end

   // Set wins over a same-cycle clear, so a transmit end is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_end_flag_r <= 1'b0;
      end else if (ninth_rise && tx_buffer_empty_flag_r) begin
         tx_end_flag_r <= 1'b1;
      end else if (wr_txb || clr_tx_end_flag_sw) begin
         tx_end_flag_r <= 1'b0;
      end
   end

   // A loss is kept even if software clears in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         al_r <= 1'b0;
      end else if (arb_lost) begin
         al_r <= 1'b1;
      end else if (clr_al_sw) begin
         al_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   always_comb begin
      ev_set = 8'h00;
      ev_set[`TX_BUFFER_EMPTY_FLAG_BIT] = set_tx_buffer_empty_flag & ~wr_txb & ~tx_buffer_empty_flag_r;
      ev_set[`TX_END_FLAG_BIT] = ninth_rise & tx_buffer_empty_flag_r;
      ev_set[`AL_BIT] = arb_lost;
   end

   // Write one clears; a new event in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_r <= `EVENT_RST;
      end else if (wr_ev) begin
         ev_r <= (ev_r & ~pwdata[7:0]) | ev_set;
      end else begin
         ev_r <= ev_r | ev_set;
      end
   end

   // Mask shares the event layout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= `EVENT_RST;
      end else if (wr_mask) begin
         mask_r <= pwdata[7:0];
      end
   end

   // Level output, one cycle behind the event bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_r & mask_r);
      end
   end
endmodule

// ==== verif/i2c_tx_properties.sv ====
// Purpose: port-level properties of the transmit path
// Assumes: APB master keeps one idle cycle between transfers
// Notes: bound to the top module below
`timescale 1ns/1ns
`include "i2c_tx_consts.svh"
module i2c_tx_properties
   import i2c_tx_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and status
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire i2c_tx_pkg::op_mode_t mode,
   input wire logic irq
);
   localparam logic [17:0] ctrl_addr = {`BUS_CONTROL_ONE_IDX, 2'b00};
   localparam logic [17:0] bad_addr = 18'h3c1e4;
   // ----
   // Properties
   // ----
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("access not answered after one wait state");
   a_idle_quiet: assert property (!psel |=> !pready && !pslverr)
      else $error("answer without a request");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_unmapped_err: assert property (psel && penable && pready && paddr == bad_addr |-> pslverr)
      else $error("unmapped access not refused");
   a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data above the byte not zero");
   a_mode_follows: assert property (psel && penable && pready && pwrite
      && paddr == ctrl_addr |-> ##2 mode == $past(pwdata[5:4], 2))
      else $error("mode does not follow the select bits");
   a_no_pull_high: assert property ($fell(sda_oe_n) |-> !scl_in)
      else $error("SDA pulled low while SCL high");
   a_open_drain: assert property (sda_out == 1'b0)
      else $error("SDA driven high");
   cover property (pready && pslverr);
   cover property ($rose(irq));
   cover property (mode == MASTER_TX && !sda_oe_n);
endmodule

bind i2c_master_transmit_path i2c_tx_properties i2c_tx_properties_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .scl_in, .sda_in, .sda_out, .sda_oe_n, .mode, .irq);

// ==== verif/i2c_slave_model.sv ====
// Purpose: receiving slave on the two-wire bus
// Assumes: SCL comes from the bench, SDA has a pull-up
// Notes: lose_at pulls SDA low at one bit, as a rival master would
`timescale 1ns/1ns
module i2c_slave_model (
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   // Fault command, 4'hf for none
   input wire logic [3:0] lose_at,
   // Pull-down on SDA
   output logic pull
);
   logic [7:0] sh = 8'h00;
   int cnt = 0;
   logic [7:0] rx_q[$];
   initial pull = 1'b0;
   // MSB first; ninth rise closes the byte
   always @(posedge scl) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda};
         cnt++;
         if (cnt == 8) begin
            rx_q.push_back(sh);
         end
      end else begin
         cnt = 0;
      end
   end
   // Changes only while SCL low
   always @(negedge scl) begin
      pull = (cnt == 8) || (cnt == int'(lose_at));
   end
endmodule

// ==== verif/tb_i2c_master_transmit_path.sv ====
// Purpose: self-checking bench of the I2C master transmit path
// Assumes: SCL stands low between frames, as after a start
// Notes: expected flags and bytes kept in integers and a queue
`timescale 1ns/1ns
`include "i2c_tx_consts.svh"
module tb_i2c_master_transmit_path;
   import i2c_tx_pkg::*;
   localparam logic [17:0] addr_ctrl = {`BUS_CONTROL_ONE_IDX, 2'b00};
   localparam logic [17:0] addr_stat = {`BUS_STATUS_IDX, 2'b00};
   localparam logic [17:0] addr_txb = {`TRANSMIT_BUFFER_IDX, 2'b00};
   localparam logic [17:0] addr_ev = {`EVENT_STATUS_IDX, 2'b00};
   localparam logic [17:0] addr_mask = {`EVENT_MASK_IDX, 2'b00};
   logic pclk, presetn, psel, penable, pwrite, pull, pready, pslverr;
   logic scl = 1'b0;
   logic sda_out, sda_oe_n, irq, e;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] lose_at = 4'hf;
   logic [7:0] seed, b;
   logic [7:0] exp_q[$];
   op_mode_t mode;
   wire sda = sda_oe_n & ~pull;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int exp_stat = 0;

   i2c_master_transmit_path i2c_master_transmit_path_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mode(mode), .irq(irq));
   i2c_slave_model i2c_slave_model_inst (.scl(scl), .sda(sda), .lose_at(lose_at),
      .pull(pull));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Whole run is near 400 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         end_sim();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic end_sim();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [7:0] lfsr();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         bad_count++;
      end
   endtask
   // Idle edge at the end keeps psel from two writes in one step
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, ex, q);
   endtask
   // Nine clocks of 320 ns, eight pclk each, moved on pclk edges
   task automatic frame();
      repeat (9) begin
         repeat (4) @(posedge pclk);
         scl <= 1'b1;
         repeat (4) @(posedge pclk);
         scl <= 1'b0;
      end
      repeat (12) @(posedge pclk);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      seed = 8'h20;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(addr_txb, 32'hff, "txb reset");
      rd(addr_stat, 32'h0, "status reset");
      b = lfsr();
      apb(1'b1, addr_txb, b);
      rd(addr_txb, {24'h0, b}, "txb readback");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, addr_ctrl, 8'(i << 4));
         if (i[0]) exp_stat = 32'h80;
         repeat (2) @(posedge pclk);
         chk("mode", i, mode);
         rd(addr_stat, exp_stat, "status after mode");
      end
      apb(1'b1, addr_ctrl, 8'h20);
      apb(1'b1, addr_stat, 8'h00);
      rd(addr_stat, 32'h0, "status zero write");
      apb(1'b1, addr_mask, 8'h40);
      apb(1'b1, addr_ctrl, 8'h30);
      for (int k = 0; k < 2; k++) begin
         b = lfsr();
         exp_q.push_back(b);
         apb(1'b1, addr_txb, b);
         rd(addr_stat, k ? 32'h0 : 32'h80, "status after load");
      end
      frame();
      rd(addr_stat, 32'h80, "status first frame");
      chk("irq masked", 1'b0, irq);
      frame();
      rd(addr_stat, 32'hc0, "status second frame");
      chk("irq raised", 1'b1, irq);
      apb(1'b1, addr_ev, 8'h40);
      @(posedge pclk);
      chk("irq cleared", 1'b0, irq);
      apb(1'b1, addr_stat, 8'h80);
      rd(addr_stat, 32'h80, "tx_end_flag zero write");
      while (exp_q.size() > 0) begin
         chk("slave byte", exp_q.pop_front(), i2c_slave_model_inst.rx_q.pop_front());
      end
      lose_at <= 4'h1;
      apb(1'b1, addr_txb, 8'hff);
      frame();
      lose_at <= 4'hf;
      apb(1'b0, addr_stat, 8'h00);
      chk("arbitration flag", 32'h04, q & 32'h04);
      rd(addr_ctrl, 32'h0, "control after loss");
      chk("mode after loss", SLAVE_RX, mode);
      apb(1'b0, addr_ctrl + 18'h4, 8'h00);
      chk("slverr", 1'b1, e);
      chk("unmapped data", 32'h0, q);
      end_sim();
   end
endmodule
